// >>> dv/awp_playback_assertions.sv
`timescale 1ns/1ps
module awp_playback_assertions
   import awp_pkg::*;
#(
   parameter int unsigned MEM_DEPTH = 1024,
   parameter int unsigned MARK_W    = 4
) (
   // Clock and reset
   input  wire logic                       clk_i,
   input  wire logic                       reset_n_i,
   // Control
   input  wire logic                       enable_i,
   input  wire awp_src_e                   source_i,
   input  wire logic [$clog2(MEM_DEPTH):0] wave_len_i,
   input  wire logic [PHASE_W-1:0]         tone_step_i,
   input  wire logic [15:0]                samples_per_period_i,
   input  wire logic [PHASE_W-1:0]         q_phase_i,
   input  wire logic signed [SAMPLE_W-1:0] const_i_i,
   input  wire logic signed [SAMPLE_W-1:0] const_q_i,
   // Status and stream
   input  wire logic                       running_o,
   input  wire logic                       enable_err_o,
   input  wire logic [PHASE_W-1:0]         play_rate_o,
   input  wire logic                       spp_limited_o,
   input  wire awp_iq_s                    iq_o,
   input  wire logic [MARK_W-1:0]          marker_o,
   input  wire logic                       out_valid_o,
   input  wire logic                       out_ready_i
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // Wide product so an overflowing rate is not hidden by truncation
   logic [63:0] prod;
   logic        sine;
   assign prod = 64'(tone_step_i) * 64'(samples_per_period_i);
   assign sine = (source_i == AWP_SRC_SINE);

   AST_EMPTY_ERR: assert property (enable_i && source_i == AWP_SRC_WAVE &&
      wave_len_i == '0 && !running_o |=> enable_err_o) else $error("empty enable not refused");
   AST_ERR_IDLE: assert property (enable_err_o |-> !running_o)
      else $error("running despite enable error");
   AST_SINE_RATE: assert property (sine && !spp_limited_o |-> play_rate_o == prod[31:0])
      else $error("sine clock rate wrong");
   AST_RATE_MAX: assert property (sine |-> play_rate_o <= MAX_CLK_HZ)
      else $error("sine clock rate above maximum");
   AST_LIMIT_FLAG: assert property (sine && tone_step_i != '0 |->
      spp_limited_o == (prod > MAX_CLK_HZ)) else $error("limit flag wrong");
   AST_ZERO_PHASE: assert property (running_o && sine && q_phase_i == '0 && out_valid_o
      |-> iq_o.i == iq_o.q) else $error("zero offset sine differs on I and Q");
   AST_RECT_EQ: assert property (source_i == AWP_SRC_RECT && out_valid_o
      |-> iq_o.i == iq_o.q) else $error("rectangle differs on I and Q");
   AST_CONST_VAL: assert property (running_o && source_i == AWP_SRC_CONST && out_valid_o
      |-> iq_o.i == const_i_i && iq_o.q == const_q_i) else $error("constant value wrong");
   AST_HOLD: assert property (out_valid_o && !out_ready_i |=> out_valid_o &&
      $stable(iq_o) && $stable(marker_o)) else $error("stalled word changed");
   AST_FIRST: assert property ($rose(running_o) && source_i == AWP_SRC_WAVE
      |=> out_valid_o) else $error("first sample late");

   cover property (enable_err_o);
   cover property (out_valid_o && !out_ready_i ##1 out_valid_o && out_ready_i);
   cover property (running_o && source_i == AWP_SRC_CONST && out_valid_o && out_ready_i);
endmodule

bind awp_playback awp_playback_assertions #(.MEM_DEPTH(MEM_DEPTH), .MARK_W(MARK_W)) u_chk (
   .clk_i(clk_i), .reset_n_i(reset_n_i), .enable_i(enable_i), .source_i(source_i),
   .wave_len_i(wave_len_i), .tone_step_i(tone_step_i),
   .samples_per_period_i(samples_per_period_i), .q_phase_i(q_phase_i),
   .const_i_i(const_i_i), .const_q_i(const_q_i), .running_o(running_o),
   .enable_err_o(enable_err_o), .play_rate_o(play_rate_o), .spp_limited_o(spp_limited_o),
   .iq_o(iq_o), .marker_o(marker_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i)
);

// >>> dv/awp_playback_tb.sv
`timescale 1ns/1ps
module awp_playback_tb;
   import awp_pkg::*;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic clk_i = 0, reset_n_i = 1, enable_i = 0, marker_en_i = 0, iq_we_i = 0, mk_we_i = 0;
   awp_src_e            source_i = AWP_SRC_WAVE;
   logic [10:0]         wave_len_i = '0;
   logic [31:0]         rate_step_i = 32'h8000_0000, tone_step_i = '0, q_phase_i = '0;
   logic [15:0]         samples_per_period_i = 16'h0004;
   logic signed [15:0]  rect_amp_i = '0, level_shift_i = '0, const_i_i = '0, const_q_i = '0;
   logic [9:0]          iq_addr_i = '0, mk_addr_i = '0;
   awp_iq_s             iq_data_i = '0, iq_o, w, s [5];
   logic [3:0]          mk_data_i = '0, marker_o, m;
   logic [31:0]         play_rate_o;
   logic [1:0]          pace = '0;
   logic running_o, enable_err_o, spp_limited_o, out_valid_o, out_ready_i, take;
   int                  err_total = 0, checks_done = 0;
   realtime             t [3];

   awp_playback u_dut (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .enable_i(enable_i), .source_i(source_i),
      .wave_len_i(wave_len_i), .marker_en_i(marker_en_i), .rate_step_i(rate_step_i),
      .tone_step_i(tone_step_i), .samples_per_period_i(samples_per_period_i),
      .q_phase_i(q_phase_i), .rect_amp_i(rect_amp_i), .level_shift_i(level_shift_i),
      .const_i_i(const_i_i), .const_q_i(const_q_i), .iq_we_i(iq_we_i),
      .iq_addr_i(iq_addr_i), .iq_data_i(iq_data_i), .mk_we_i(mk_we_i),
      .mk_addr_i(mk_addr_i), .mk_data_i(mk_data_i), .running_o(running_o),
      .enable_err_o(enable_err_o), .play_rate_o(play_rate_o), .spp_limited_o(spp_limited_o),
      .iq_o(iq_o), .marker_o(marker_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i));
   awp_sink u_sink (.clk_i(clk_i), .reset_n_i(reset_n_i), .pace_i(pace),
      .valid_i(out_valid_o), .ready_o(out_ready_i), .take_o(take));

   initial begin
      forever #50 clk_i = ~clk_i;
   end
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic get();
      for (int k = 0; k < 3000; k++) begin
         @(negedge clk_i);
         if (take === 1'b1) begin
            w = iq_o;
            m = marker_o;
            @(posedge clk_i);
            return;
         end
      end
      chk(32'h0000_0000, 32'h0000_0001);
   endtask
   task automatic go(input awp_src_e src);
      @(posedge clk_i);
      source_i <= src;
      enable_i <= 1'b1;
      @(posedge clk_i);
      #1;
   endtask
   // Drain so stale words of the last source never reach the next test
   task automatic stop();
      @(posedge clk_i);
      enable_i <= 1'b0;
      pace <= 2'h0;
      for (int k = 0; k < 60 && out_valid_o !== 1'b0; k++) @(negedge clk_i);
      @(posedge clk_i);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_refuse();
      go(AWP_SRC_WAVE);
      repeat (2) @(posedge clk_i);
      #1;
      chk(enable_err_o, 1'b1);
      chk(running_o, 1'b0);
      chk(out_valid_o, 1'b0);
      stop();
      $display("t_refuse done");
   endtask
   task automatic t_wave();
      for (int j = 0; j < 3; j++) begin
         @(posedge clk_i);
         iq_we_i <= 1'b1;
         mk_we_i <= 1'b1;
         iq_addr_i <= 10'(j);
         mk_addr_i <= 10'(j);
         iq_data_i <= '{i: 16'(j * 256), q: 16'(-j * 256)};
         mk_data_i <= 4'(j + 5);
      end
      @(posedge clk_i);
      iq_we_i <= 1'b0;
      mk_we_i <= 1'b0;
      wave_len_i <= 11'h003;
      marker_en_i <= 1'b1;
      pace <= 2'h2;
      go(AWP_SRC_WAVE);
      repeat (30) @(posedge clk_i);
      pace <= 2'h1;
      for (int n = 0; n < 14; n++) begin
         get();
         if (n % 2 == 0) begin
            chk(w.i, 16'((n / 2) % 3 * 256));
            chk(w.q, 16'(-((n / 2) % 3) * 256));
            chk(m, 4'((n / 2) % 3 + 5));
         end
      end
      stop();
      // Markers off must leave the marker lane at zero
      marker_en_i <= 1'b0;
      go(AWP_SRC_WAVE);
      get();
      chk(w.i, 16'h0000);
      chk(m, 4'h0);
      stop();
      $display("t_wave done");
   endtask
   task automatic t_sine();
      tone_step_i <= 32'h0000_03E8;
      q_phase_i <= 32'hC000_0000;
      go(AWP_SRC_SINE);
      chk(play_rate_o, 32'h0000_0FA0);
      chk(spp_limited_o, 1'b0);
      get();
      chk(w.i, 16'h0000);
      chk(w.q < -16'sh7530, 1'b1);
      get();
      chk(w.i > 16'sh7530, 1'b1);
      chk(w.q, 16'h0000);
      stop();
      q_phase_i <= '0;
      go(AWP_SRC_SINE);
      for (int n = 0; n < 4; n++) begin
         get();
         chk(w.i, w.q);
      end
      stop();
      tone_step_i <= 32'h11E1_A300;
      go(AWP_SRC_SINE);
      chk(play_rate_o, 32'h23C3_4600);
      chk(spp_limited_o, 1'b1);
      stop();
      $display("t_sine done");
   endtask
   task automatic t_rect();
      tone_step_i <= 32'h0000_03E8;
      rect_amp_i <= 16'h1000;
      level_shift_i <= 16'h0100;
      go(AWP_SRC_RECT);
      for (int n = 0; n < 5; n++) begin
         get();
         s[n] = w;
         chk(w.i, w.q);
      end
      chk(s[0] === s[1] && s[2] === s[3] && s[0] !== s[2], 1'b1);
      chk(s[4], s[0]);
      stop();
      $display("t_rect done");
   endtask
   task automatic t_const();
      const_i_i <= 16'h1234;
      const_q_i <= 16'hFFFB;
      go(AWP_SRC_CONST);
      for (int n = 0; n < 3; n++) begin
         get();
         t[n] = $realtime;
         chk(w, 32'h1234_FFFB);
      end
      chk(32'((t[2] - t[1]) / 100.0), CONST_DIV);
      stop();
      go(AWP_SRC_NOISE);
      get();
      s[0] = w;
      get();
      chk(w !== s[0], 1'b1);
      stop();
      $display("t_const done");
   endtask
   // ---------------------------------------------------------------
   // Sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      // Async reset needs a real falling edge to act
      reset_n_i <= 1'b0;
      repeat (12) @(posedge clk_i);
      reset_n_i <= 1'b1;
      t_refuse();
      t_wave();
      t_sine();
      t_rect();
      t_const();
      end_sim();
   end
   initial begin
      repeat (40000) @(posedge clk_i);
      err_total++;
      end_sim();
   end
endmodule

// >>> dv/awp_sink.sv
`timescale 1ns/1ps
module awp_sink (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   // Pacing: 0 ready, 1 every other cycle, 2 stalled
   input  wire logic [1:0] pace_i,
   // Stream handshake
   input  wire logic       valid_i,
   output logic            ready_o,
   output logic            take_o
);
   // Converter side has no backpressure of its own; pacing exercises the FIFO
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ready_o <= 1'b0;
      end else begin
         ready_o <= (pace_i == 2'h0) || (pace_i == 2'h1 && !ready_o);
      end
   end
   assign take_o = valid_i && ready_o;
endmodule

// >>> src/awp_fifo.sv
`timescale 1ns/1ps
module awp_fifo #(
   parameter int unsigned WIDTH = 36,
   parameter int unsigned DEPTH = 16
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             reset_n_i,
   // Write side
   input  wire logic [WIDTH-1:0] wr_data_i,
   input  wire logic             wr_valid_i,
   output logic                  wr_ready_o,
   // Read side
   output logic [WIDTH-1:0]      rd_data_o,
   output logic                  rd_valid_o,
   input  wire logic             rd_ready_i
);
   localparam int unsigned AW = $clog2(DEPTH);

   // Elaboration check
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("DEPTH must be a power of two");
   end

   typedef struct packed {
      logic [AW:0] wptr;
      logic [AW:0] rptr;
   } awp_fifo_state_s;

   awp_fifo_state_s  s_q;
   awp_fifo_state_s  s_d;
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic             do_wr;
   logic             do_rd;

   assign wr_ready_o = (s_q.wptr - s_q.rptr) != (AW+1)'(DEPTH);
   assign rd_valid_o = s_q.wptr != s_q.rptr;
   assign rd_data_o  = mem_q[s_q.rptr[AW-1:0]];
   assign do_wr      = wr_valid_i && wr_ready_o;
   assign do_rd      = rd_valid_o && rd_ready_i;

   always_comb begin
      s_d = s_q;
      if (do_wr) s_d.wptr = s_q.wptr + 1'b1;
      if (do_rd) s_d.rptr = s_q.rptr + 1'b1;
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Storage needs no reset
   always_ff @(posedge clk_i) begin
      if (do_wr) mem_q[s_q.wptr[AW-1:0]] <= wr_data_i;
   end
endmodule

// >>> src/awp_pkg.sv
package awp_pkg;

   // ---------------------------------------------------------------
   // Constants
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned CONST_RATE_HZ   = 10_000;
   localparam int unsigned CONST_DIV       = CLK_HZ / CONST_RATE_HZ;
   localparam int unsigned MAX_CLK_HZ      = 600_000_000;
   localparam int unsigned MIN_WAVE_LEN    = 512;
   localparam int unsigned SAMPLE_W        = 16;
   localparam int unsigned PHASE_W         = 32;
   localparam int unsigned LUT_W           = 8;
   localparam logic [15:0] LFSR_SEED       = 16'hACE1;

   typedef enum logic [2:0] {
      AWP_SRC_WAVE,
      AWP_SRC_SINE,
      AWP_SRC_RECT,
      AWP_SRC_CONST,
      AWP_SRC_NOISE
   } awp_src_e;

   typedef enum {
      AWP_IDLE,
      AWP_RUN
   } awp_state_e;

   typedef struct packed {
      logic signed [SAMPLE_W-1:0] i;
      logic signed [SAMPLE_W-1:0] q;
   } awp_iq_s;

endpackage

// >>> src/awp_playback.sv
`timescale 1ns/1ps
module awp_playback
   import awp_pkg::*;
#(
   parameter int unsigned MEM_DEPTH = 1024,
   parameter int unsigned MARK_W    = 4,
   parameter int unsigned FIFO_DEPTH = 16
) (
   // Clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         reset_n_i,
   // Control
   input  wire logic                         enable_i,
   input  wire awp_src_e                     source_i,
   input  wire logic [$clog2(MEM_DEPTH):0]   wave_len_i,
   input  wire logic                         marker_en_i,
   input  wire logic [PHASE_W-1:0]           rate_step_i,
   input  wire logic [PHASE_W-1:0]           tone_step_i,
   input  wire logic [15:0]                  samples_per_period_i,
   input  wire logic [PHASE_W-1:0]           q_phase_i,
   input  wire logic signed [SAMPLE_W-1:0]   rect_amp_i,
   input  wire logic signed [SAMPLE_W-1:0]   level_shift_i,
   input  wire logic signed [SAMPLE_W-1:0]   const_i_i,
   input  wire logic signed [SAMPLE_W-1:0]   const_q_i,
   // I/Q sample memory write port
   input  wire logic                         iq_we_i,
   input  wire logic [$clog2(MEM_DEPTH)-1:0] iq_addr_i,
   input  wire awp_iq_s                      iq_data_i,
   // Marker memory write port
   input  wire logic                         mk_we_i,
   input  wire logic [$clog2(MEM_DEPTH)-1:0] mk_addr_i,
   input  wire logic [MARK_W-1:0]            mk_data_i,
   // Status
   output logic                              running_o,
   output logic                              enable_err_o,
   output logic [PHASE_W-1:0]                play_rate_o,
   output logic                              spp_limited_o,
   // Output stream
   output awp_iq_s                           iq_o,
   output logic [MARK_W-1:0]                 marker_o,
   output logic                              out_valid_o,
   input  wire logic                         out_ready_i
);
   localparam int unsigned AW = $clog2(MEM_DEPTH);
   localparam int unsigned FW = 2*SAMPLE_W + MARK_W;

   // Elaboration checks
   if (MEM_DEPTH < MIN_WAVE_LEN) begin : g_bad_depth
      $error("MEM_DEPTH below minimum waveform length");
   end
   if (MARK_W < 1) begin : g_bad_mark
      $error("MARK_W must be at least one");
   end

   // ---------------------------------------------------------------
   // Sample and marker memories
   // ---------------------------------------------------------------
   awp_iq_s           iq_mem_q [MEM_DEPTH];
   logic [MARK_W-1:0] mk_mem_q [MEM_DEPTH];

   always_ff @(posedge clk_i) begin
      if (iq_we_i) iq_mem_q[iq_addr_i] <= iq_data_i;
      if (mk_we_i) mk_mem_q[mk_addr_i] <= mk_data_i;
   end

   // ---------------------------------------------------------------
   // Quarter-free sine table, 256 entries
   // ---------------------------------------------------------------
   function automatic logic signed [SAMPLE_W-1:0] sine_lut(input logic [LUT_W-1:0] a);
      real x;
      x = $sin(2.0 * 3.14159265358979 * real'(a) / 256.0) * 32767.0;
      return SAMPLE_W'($rtoi(x));
   endfunction

   logic signed [SAMPLE_W-1:0] sine_rom [256];
   for (genvar g = 0; g < 256; g++) begin : g_rom
      assign sine_rom[g] = sine_lut(LUT_W'(g));
   end

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      awp_state_e       st;
      logic             err;
      logic [AW-1:0]    addr;
      logic [PHASE_W:0] frac;
      logic [PHASE_W-1:0] ph;
      logic [15:0]      rect_cnt;
      logic             rect_hi;
      logic [15:0]      cdiv;
      logic [15:0]      lfsr;
      awp_iq_s          prev;
      awp_iq_s          cur;
      logic [MARK_W-1:0] mk;
      logic             loaded;
   } awp_state_s;

   awp_state_s s_q;
   awp_state_s s_d;

   // ---------------------------------------------------------------
   // Rate derivation
   // ---------------------------------------------------------------
   logic [47:0] prod;
   logic [47:0] spp_quo;
   logic [15:0] spp_max;
   logic [15:0] spp_eff;
   logic [AW:0] eff_len;

   always_comb begin
      // Saturate, a low tone would otherwise wrap the limit
      spp_quo = (tone_step_i == '0) ? 48'h0000_0000_FFFF
              : 48'(MAX_CLK_HZ) / 48'(tone_step_i);
      spp_max = (spp_quo > 48'h0000_0000_FFFF) ? 16'hFFFF : spp_quo[15:0];
      spp_eff = (samples_per_period_i > spp_max) ? spp_max : samples_per_period_i;
      prod    = 48'(tone_step_i) * 48'(spp_eff);
   end

   assign play_rate_o   = PHASE_W'(prod);
   assign spp_limited_o = samples_per_period_i > spp_max;

   // Waveform wraps after wave_len_i points as given, with no repeat up to a minimum length
   assign eff_len = wave_len_i;

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   logic            fifo_ready;
   logic            push;
   awp_iq_s         smp;
   awp_iq_s         rd_iq;
   logic [FW-1:0]   fifo_out;
   logic signed [SAMPLE_W+SAMPLE_W-1:0] interp;
   logic signed [SAMPLE_W:0] rect_v;
   logic [LUT_W-1:0] ia;
   logic [LUT_W-1:0] qa;

   assign rd_iq = iq_mem_q[s_q.addr];

   always_comb begin
      s_d    = s_q;
      push   = 1'b0;
      smp    = '0;
      interp = '0;
      rect_v = '0;
      ia     = s_q.ph[PHASE_W-1 -: LUT_W];
      qa     = LUT_W'((s_q.ph + q_phase_i) >> (PHASE_W - LUT_W));
      s_d.lfsr = {s_q.lfsr[14:0], s_q.lfsr[15] ^ s_q.lfsr[13] ^ s_q.lfsr[12] ^ s_q.lfsr[10]};
      case (s_q.st)
         AWP_IDLE: begin
            s_d.err = 1'b0;
            if (enable_i) begin
               if (source_i == AWP_SRC_WAVE && wave_len_i == '0) begin
                  s_d.err = 1'b1;
               end else begin
                  s_d.st   = AWP_RUN;
                  s_d.addr = (wave_len_i > (AW+1)'(1)) ? AW'(1) : '0;
                  s_d.frac = '0;
                  s_d.ph   = '0;
                  s_d.cdiv = '0;
                  s_d.rect_cnt = '0;
                  s_d.rect_hi  = 1'b1;
                  // Preload point zero so the first output is stored sample zero
                  s_d.prev = iq_mem_q[0];
                  s_d.mk   = marker_en_i ? mk_mem_q[0] : '0;
               end
            end
         end
         AWP_RUN: begin
            if (!enable_i) begin
               s_d.st = AWP_IDLE;
            end else if (fifo_ready) begin
               case (source_i)
                  AWP_SRC_WAVE: begin
                     // Linear interpolation between stored points
                     interp = 32'((32'(s_q.prev.i)
                            * (33'sh1_0000 - 33'(s_q.frac[PHASE_W-1 -: 16]))
                            + 32'(rd_iq.i) * 32'(s_q.frac[PHASE_W-1 -: 16])) >>> 16);
                     smp.i  = SAMPLE_W'(interp);
                     interp = 32'((32'(s_q.prev.q)
                            * (33'sh1_0000 - 33'(s_q.frac[PHASE_W-1 -: 16]))
                            + 32'(rd_iq.q) * 32'(s_q.frac[PHASE_W-1 -: 16])) >>> 16);
                     smp.q  = SAMPLE_W'(interp);
                     push   = 1'b1;
                     s_d.frac = {1'b0, s_q.frac[PHASE_W-1:0]} + {1'b0, rate_step_i};
                     if (s_d.frac[PHASE_W]) begin
                        s_d.prev = rd_iq;
                        s_d.mk   = marker_en_i ? mk_mem_q[s_q.addr] : '0;
                        s_d.addr = (AW+1)'(s_q.addr) + 1'b1 >= eff_len
                                 ? '0 : s_q.addr + 1'b1;
                        s_d.frac[PHASE_W] = 1'b0;
                     end
                  end
                  AWP_SRC_SINE: begin
                     smp.i  = sine_rom[ia];
                     smp.q  = sine_rom[qa];
                     push   = 1'b1;
                     // Step of 2^32/spp truncated, so whole periods repeat exactly only when spp is a power of two
                     s_d.ph = s_q.ph
                            + PHASE_W'(33'h1_0000_0000 / 33'(spp_eff == '0 ? 16'h0001 : spp_eff));
                  end
                  AWP_SRC_RECT: begin
                     rect_v = (s_q.rect_hi ? 17'(rect_amp_i) : -17'(rect_amp_i))
                            + 17'(level_shift_i);
                     smp.i  = SAMPLE_W'(rect_v);
                     smp.q  = SAMPLE_W'(rect_v);
                     push   = 1'b1;
                     if (s_q.rect_cnt >= (spp_eff >> 1) - 16'h0001) begin
                        s_d.rect_cnt = '0;
                        s_d.rect_hi  = ~s_q.rect_hi;
                     end else begin
                        s_d.rect_cnt = s_q.rect_cnt + 16'h0001;
                     end
                  end
                  AWP_SRC_CONST: begin
                     smp.i = const_i_i;
                     smp.q = const_q_i;
                     if (s_q.cdiv >= 16'(CONST_DIV - 1)) begin
                        s_d.cdiv = '0;
                        push     = 1'b1;
                     end else begin
                        s_d.cdiv = s_q.cdiv + 16'h0001;
                     end
                  end
                  AWP_SRC_NOISE: begin
                     smp.i = s_q.lfsr;
                     smp.q = {s_q.lfsr[7:0], s_q.lfsr[15:8]};
                     push  = 1'b1;
                  end
                  default: push = 1'b0;
               endcase
            end
         end
         default: s_d.st = AWP_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_q      <= '0;
         s_q.st   <= AWP_IDLE;
         s_q.lfsr <= LFSR_SEED;
         s_q.rect_hi <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign running_o    = s_q.st == AWP_RUN;
   assign enable_err_o = s_q.err;

   // ---------------------------------------------------------------
   // Output buffer keeps markers in the same word as I/Q
   // ---------------------------------------------------------------
   awp_fifo #(
      .WIDTH (FW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i      (clk_i),
      .reset_n_i  (reset_n_i),
      // Marker of the base point, so it changes together with its sample
      .wr_data_i  ({smp, (source_i == AWP_SRC_WAVE) ? s_q.mk : MARK_W'(0)}),
      .wr_valid_i (push),
      .wr_ready_o (fifo_ready),
      .rd_data_o  (fifo_out),
      .rd_valid_o (out_valid_o),
      .rd_ready_i (out_ready_i)
   );

   assign iq_o     = fifo_out[FW-1 -: 2*SAMPLE_W];
   assign marker_o = fifo_out[MARK_W-1:0];
endmodule
